// [tpu_pkg.sv]
// Constants and carrier types of the eight-channel timer and PWM unit.
// Assumes a 32-bit APB register bus with word-aligned registers.
package tpu_pkg;

  localparam int NCH = 8;
  localparam int CH_FIVE = 5;
  localparam int CNT_W = 16;
  localparam int PRE_W = 10;
  localparam int ADDR_W = 12;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] OFS_STOP_STATE  = 12'h000;
  localparam logic [11:0] OFS_STOP_SET    = 12'h004;
  localparam logic [11:0] OFS_STOP_CLEAR  = 12'h008;
  localparam logic [11:0] OFS_START_SET   = 12'h00C;
  localparam logic [11:0] OFS_START_CLEAR = 12'h010;
  localparam logic [11:0] OFS_RUN_STATE   = 12'h014;
  localparam logic [11:0] OFS_MASK        = 12'h018;
  localparam logic [11:0] OFS_FLAGS       = 12'h01C;
  localparam logic [11:0] OFS_CH_BASE     = 12'h080;
  localparam logic [1:0]  CH_CTRL = 2'h0;
  localparam logic [1:0]  CH_FULL = 2'h1;
  localparam logic [1:0]  CH_HALF = 2'h2;
  localparam logic [1:0]  CH_CNT  = 2'h3;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int WD_BIT = 16;
  localparam int HALF_LSB = 16;
  localparam int CTL_W = 9;
  localparam int CTL_DIV_LSB = 3;
  localparam int CTL_INIT = 6;
  localparam int CTL_PWM = 7;
  localparam int CTL_SD = 8;
  localparam logic [2:0] SRC_PCLK = 3'h1;
  localparam logic [2:0] SRC_SLOW = 3'h2;
  localparam logic [2:0] SRC_XTAL = 3'h4;
  localparam logic [CTL_W-1:0] CTL_RESET = 9'h000;

  typedef struct packed {
    logic [CTL_W-1:0] ctrl;
    logic [CNT_W-1:0] full;
    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] cnt;
    logic [PRE_W-1:0] pre;
    logic             stop;
    logic             run;
    logic             drain;
    logic             pwm;
    logic             fflag;
    logic             hflag;
    logic             full_match_mask;
    logic             half_match_mask;
  } tpu_ch_t;

  typedef struct packed {
    tpu_ch_t [NCH-1:0] ch;
    logic              wd_stop;
    logic [2:0]        slow_sync;
    logic [2:0]        xtal_sync;
    logic [31:0]       prdata;
  } tpu_state_t;

endpackage

// [tpu_timer_pwm.sv]
// Eight-channel timer and PWM unit with clock gating and start/stop registers.
// Assumes an APB master on pclk; slow and crystal clocks arrive as async levels.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - stop-clear ones ungate channel or watchdog clock
// - half 0, full 1 halves the input rate
// - half above full gives no half match, except the channel five half flag
// - control bit picks abrupt or graceful shutdown when PWM is on
// - start-set one starts that channel counter unless its stop bit is set
// - start-clear one stops that channel counter
// - every channel drives its own PWM pin
// - full match sets period, half sets duty
// - channel five always shuts down abruptly
// - channel five flags set on any equality
// - stop bit gates clock and blocks registers
module tpu_timer_pwm (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [tpu_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      slow_reference_clock,
  input  wire logic                      crystal_clock,
  output logic      [tpu_pkg::NCH-1:0]   pwm_out,
  output logic                           watchdog_gate_state
);

  tpu_pkg::tpu_state_t q;
  tpu_pkg::tpu_state_t next_q;

  logic                    wr;
  logic                    rd_setup;
  logic                    err;
  logic                    slow_edge;
  logic                    xtal_edge;
  logic                    ch_sel;
  logic [2:0]              ch_idx;
  logic [tpu_pkg::NCH-1:0] tick;
  logic [tpu_pkg::NCH-1:0] fhit;
  logic [tpu_pkg::NCH-1:0] hhit;
  logic [tpu_pkg::NCH-1:0] fset;
  logic [tpu_pkg::NCH-1:0] hset;
  logic [tpu_pkg::NCH-1:0] stop_vec;
  logic [tpu_pkg::NCH-1:0] run_vec;
  logic [31:0]             rd;

  // ****************************************
  // APB decode
  // ****************************************
  assign pready   = clk_en;
  assign wr       = psel & penable & pwrite & clk_en;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign ch_sel   = (paddr[11:7] == tpu_pkg::OFS_CH_BASE[11:7]);
  assign ch_idx   = paddr[6:4];
  assign pslverr  = psel & penable & err;
  assign prdata   = q.prdata;
  assign watchdog_gate_state = q.wd_stop;

  always_comb begin
    err = 1'b0;
    if (ch_sel) begin
      err = stop_vec[ch_idx] | (paddr[1:0] != 2'h0);
    end else begin
      case (paddr)
        tpu_pkg::OFS_STOP_STATE, tpu_pkg::OFS_STOP_SET, tpu_pkg::OFS_STOP_CLEAR,
        tpu_pkg::OFS_START_SET, tpu_pkg::OFS_START_CLEAR, tpu_pkg::OFS_RUN_STATE,
        tpu_pkg::OFS_MASK, tpu_pkg::OFS_FLAGS: err = 1'b0;
        default: err = 1'b1;
      endcase
    end
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [2:0]              src;
    logic [tpu_pkg::PRE_W-1:0] lim;
    logic                    src_tick;
    logic                    active;
    next_q = q;
    rd = 32'h0000_0000;
    next_q.slow_sync = {q.slow_sync[1:0], slow_reference_clock};
    next_q.xtal_sync = {q.xtal_sync[1:0], crystal_clock};
    slow_edge = q.slow_sync[1] & ~q.slow_sync[2];
    xtal_edge = q.xtal_sync[1] & ~q.xtal_sync[2];
    src = 3'h0;
    lim = '0;
    src_tick = 1'b0;
    active = 1'b0;
    for (int i = 0; i < tpu_pkg::NCH; i++) begin
      stop_vec[i] = q.ch[i].stop;
      run_vec[i]  = q.ch[i].run;
      src = q.ch[i].ctrl[2:0];
      src_tick = (src == tpu_pkg::SRC_PCLK) |
                 ((src == tpu_pkg::SRC_SLOW) & slow_edge) |
                 ((src == tpu_pkg::SRC_XTAL) & xtal_edge);
      case (q.ch[i].ctrl[tpu_pkg::CTL_DIV_LSB +: 3])
        3'h0: lim = 10'h000;
        3'h1: lim = 10'h003;
        3'h2: lim = 10'h00F;
        3'h3: lim = 10'h03F;
        3'h4: lim = 10'h0FF;
        default: lim = 10'h3FF;
      endcase
      active = q.ch[i].run & ~q.ch[i].stop;
      tick[i] = active & src_tick & (q.ch[i].pre == lim);
      fhit[i] = (q.ch[i].cnt == q.ch[i].full);
      hhit[i] = (q.ch[i].cnt == q.ch[i].half) & (q.ch[i].half <= q.ch[i].full);
      if (active & src_tick) begin
        next_q.ch[i].pre = (q.ch[i].pre == lim) ? '0 : q.ch[i].pre + 10'h001;
      end
      fset[i] = tick[i] & fhit[i];
      hset[i] = tick[i] & hhit[i];
      if (i == tpu_pkg::CH_FIVE) begin
        fset[i] = fhit[i];
        hset[i] = (q.ch[i].cnt == q.ch[i].half);
      end
      if (tick[i]) begin
        next_q.ch[i].cnt = fhit[i] ? '0 : q.ch[i].cnt + 16'h0001;
        if (fhit[i]) begin
          next_q.ch[i].pwm = q.ch[i].ctrl[tpu_pkg::CTL_INIT];
          if (q.ch[i].drain) begin
            next_q.ch[i].run   = 1'b0;
            next_q.ch[i].drain = 1'b0;
          end
        end else if (hhit[i]) begin
          next_q.ch[i].pwm = ~q.ch[i].ctrl[tpu_pkg::CTL_INIT];
        end
      end
      if (!q.ch[i].ctrl[tpu_pkg::CTL_PWM]) begin
        next_q.ch[i].pwm = q.ch[i].ctrl[tpu_pkg::CTL_INIT];
      end
      next_q.ch[i].fflag = q.ch[i].fflag | fset[i];
      next_q.ch[i].hflag = q.ch[i].hflag | hset[i];
      if (wr && !ch_sel) begin
        case (paddr)
          tpu_pkg::OFS_STOP_SET: begin
            if (pwdata[i]) next_q.ch[i].stop = 1'b1;
          end
          tpu_pkg::OFS_STOP_CLEAR: begin
            if (pwdata[i]) next_q.ch[i].stop = 1'b0;
          end
          tpu_pkg::OFS_START_SET: begin
            if (pwdata[i] && !q.ch[i].stop) begin
              next_q.ch[i].run   = 1'b1;
              next_q.ch[i].drain = 1'b0;
            end
          end
          tpu_pkg::OFS_START_CLEAR: begin
            if (pwdata[i] && q.ch[i].run) begin
              if (!q.ch[i].ctrl[tpu_pkg::CTL_SD] && q.ch[i].ctrl[tpu_pkg::CTL_PWM] &&
                  i != tpu_pkg::CH_FIVE) begin
                next_q.ch[i].drain = 1'b1;
              end else begin
                next_q.ch[i].run   = 1'b0;
                next_q.ch[i].drain = 1'b0;
                next_q.ch[i].pwm   = q.ch[i].ctrl[tpu_pkg::CTL_INIT];
              end
            end
          end
          tpu_pkg::OFS_MASK: begin
            next_q.ch[i].full_match_mask = pwdata[i];
            next_q.ch[i].half_match_mask = pwdata[tpu_pkg::HALF_LSB + i];
          end
          tpu_pkg::OFS_FLAGS: begin
            next_q.ch[i].fflag = (q.ch[i].fflag & ~pwdata[i]) | fset[i];
            next_q.ch[i].hflag = (q.ch[i].hflag & ~pwdata[tpu_pkg::HALF_LSB + i]) | hset[i];
          end
          default: ;
        endcase
      end
      rd[i] = (paddr == tpu_pkg::OFS_STOP_STATE) ? q.ch[i].stop :
              (paddr == tpu_pkg::OFS_RUN_STATE)  ? q.ch[i].run  :
              (paddr == tpu_pkg::OFS_MASK)       ? q.ch[i].full_match_mask :
              (paddr == tpu_pkg::OFS_FLAGS)      ? q.ch[i].fflag : 1'b0;
      rd[tpu_pkg::HALF_LSB + i] = (paddr == tpu_pkg::OFS_MASK)  ? q.ch[i].half_match_mask :
                                  (paddr == tpu_pkg::OFS_FLAGS) ? q.ch[i].hflag : 1'b0;
    end
    if (wr && !ch_sel && pwdata[tpu_pkg::WD_BIT]) begin
      if (paddr == tpu_pkg::OFS_STOP_SET) next_q.wd_stop = 1'b1;
      if (paddr == tpu_pkg::OFS_STOP_CLEAR) next_q.wd_stop = 1'b0;
    end
    if (paddr == tpu_pkg::OFS_STOP_STATE) rd[tpu_pkg::WD_BIT] = q.wd_stop;
    // Channel registers of a gated channel neither take writes nor show data.
    if (ch_sel && !stop_vec[ch_idx]) begin
      case (paddr[3:2])
        tpu_pkg::CH_CTRL: rd = {23'h0, q.ch[ch_idx].ctrl};
        tpu_pkg::CH_FULL: rd = {16'h0, q.ch[ch_idx].full};
        tpu_pkg::CH_HALF: rd = {16'h0, q.ch[ch_idx].half};
        default:          rd = {16'h0, q.ch[ch_idx].cnt};
      endcase
      if (wr) begin
        case (paddr[3:2])
          tpu_pkg::CH_CTRL: begin
            next_q.ch[ch_idx].ctrl = pwdata[tpu_pkg::CTL_W-1:0];
            if (!q.ch[ch_idx].run) next_q.ch[ch_idx].pwm = pwdata[tpu_pkg::CTL_INIT];
          end
          tpu_pkg::CH_FULL: next_q.ch[ch_idx].full = pwdata[15:0];
          tpu_pkg::CH_HALF: next_q.ch[ch_idx].half = pwdata[15:0];
          default:          next_q.ch[ch_idx].cnt  = pwdata[15:0];
        endcase
      end
    end else if (ch_sel) begin
      rd = 32'h0000_0000;
    end
    if (rd_setup) next_q.prdata = rd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  // Each channel owns one PWM pin.
  always_comb begin
    for (int i = 0; i < tpu_pkg::NCH; i++) begin
      pwm_out[i] = q.ch[i].pwm;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_glob_wr(logic [11:0] ofs, int b);
    wr && paddr == ofs && pwdata[b];
  endsequence

  property p_stop_clear;
    s_glob_wr(tpu_pkg::OFS_STOP_CLEAR, 0) |=> !stop_vec[0];
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop not cleared");

  property p_wd_clear;
    s_glob_wr(tpu_pkg::OFS_STOP_CLEAR, tpu_pkg::WD_BIT) |=> !watchdog_gate_state;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog gate kept");

  property p_min_div;
    (clk_en && !wr && run_vec[0] && !stop_vec[0] && q.ch[0].ctrl[7:0] == 8'h81 &&
     q.ch[0].half == 16'h0000 && q.ch[0].full == 16'h0001 && q.ch[0].cnt <= 16'h0001)
      |=> pwm_out[0] != $past(pwm_out[0]);
  endproperty
  a_min_div: assert property (p_min_div) else $error("pwm not at half rate");

  property p_no_half;
    (q.ch[2].half > q.ch[2].full) |-> !hset[2];
  endproperty
  a_no_half: assert property (p_no_half) else $error("half match above full");

  property p_start;
    s_glob_wr(tpu_pkg::OFS_START_SET, 0) ##0 !stop_vec[0] |=> run_vec[0];
  endproperty
  a_start: assert property (p_start) else $error("counter did not start");

  property p_halt;
    s_glob_wr(tpu_pkg::OFS_START_CLEAR, 0) ##0 q.ch[0].ctrl[tpu_pkg::CTL_SD]
      |=> !run_vec[0];
  endproperty
  a_halt: assert property (p_halt) else $error("counter did not halt");

  property p_graceful;
    s_glob_wr(tpu_pkg::OFS_START_CLEAR, 1) ##0 run_vec[1] ##0
      (q.ch[1].ctrl[tpu_pkg::CTL_SD +: 1] == 1'b0) ##0 q.ch[1].ctrl[tpu_pkg::CTL_PWM]
      |=> run_vec[1] && q.ch[1].drain;
  endproperty
  a_graceful: assert property (p_graceful) else $error("graceful stop lost");

  property p_ch5_abrupt;
    s_glob_wr(tpu_pkg::OFS_START_CLEAR, 5) |=> !run_vec[5] && !q.ch[5].drain;
  endproperty
  a_ch5_abrupt: assert property (p_ch5_abrupt) else $error("ch5 not abrupt");

  property p_ch5_flag;
    (clk_en && q.ch[5].cnt == q.ch[5].full) |=> q.ch[5].fflag;
  endproperty
  a_ch5_flag: assert property (p_ch5_flag) else $error("ch5 flag missed");

  property p_gated;
    (clk_en && stop_vec[0]) |=> $stable(q.ch[0].cnt) && $stable(q.ch[0].ctrl);
  endproperty
  a_gated: assert property (p_gated) else $error("gated channel changed");

  property p_wrap;
    (clk_en && !wr && tick[0] && fhit[0]) |=> q.ch[0].cnt == 16'h0000 && q.ch[0].fflag &&
      (!q.ch[0].ctrl[tpu_pkg::CTL_PWM] || pwm_out[0] == q.ch[0].ctrl[tpu_pkg::CTL_INIT]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap on full match");

endmodule

`default_nettype wire

// [tpu_timer_pwm_test.sv]
// Self-checking bench for the timer and PWM unit: APB tasks and scenarios.
// Assumes the design's zero-wait APB slave on pclk and async slow clocks.
`timescale 1ns/1ns
`default_nettype none
module tpu_timer_pwm_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slow_reference_clock = 1'b0;
  logic        crystal_clock = 1'b0;
  logic [7:0]  pwm_out;
  logic        watchdog_gate_state;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          hi;
  logic [31:0] rd;
  logic        err;
  logic        p;

  tpu_timer_pwm tpu_timer_pwm_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .slow_reference_clock, .crystal_clock, .pwm_out,
    .watchdog_gate_state);

  always #2 pclk = ~pclk;
  always #8 crystal_clock = ~crystal_clock;
  always #20 slow_reference_clock = ~slow_reference_clock;

  // ****************************************
  // Bus tasks and comparisons
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] ca(input int n, input logic [1:0] r);
    return tpu_pkg::OFS_CH_BASE + 12'(n * 16) + {8'h00, r, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rng(input logic [31:0] g, input int lo, input int up);
    n_compared++;
    if ((g >= lo && g <= up) !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t got %h outside %0d..%0d", $time, g, lo, up);
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // Source and PWM enables are written last, after the counts.
  task automatic setup(input int n, input logic [31:0] c,
                       input logic [31:0] f, input logic [31:0] h);
    apb(1'b1, ca(n, tpu_pkg::CH_CTRL), c & 32'h0000_0178);
    apb(1'b1, ca(n, tpu_pkg::CH_CNT), 32'h0);
    apb(1'b1, ca(n, tpu_pkg::CH_HALF), h);
    apb(1'b1, ca(n, tpu_pkg::CH_FULL), f);
    apb(1'b1, ca(n, tpu_pkg::CH_CTRL), c);
  endtask

  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(tpu_pkg::OFS_STOP_STATE, 32'hFFFF_FFFF, 32'h0);
    rdc(tpu_pkg::OFS_RUN_STATE, 32'hFFFF_FFFF, 32'h0);
    apb(1'b1, tpu_pkg::OFS_STOP_SET, 32'h0001_00FF);
    @(negedge pclk);
    chk({31'h0, watchdog_gate_state}, 32'h1);
    apb(1'b0, ca(3, tpu_pkg::CH_FULL), 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, tpu_pkg::OFS_STOP_CLEAR, 32'h0001_0005);
    rdc(tpu_pkg::OFS_STOP_STATE, 32'hFFFF_FFFF, 32'h0000_00FA);
    chk({31'h0, watchdog_gate_state}, 32'h0);
    apb(1'b1, tpu_pkg::OFS_STOP_CLEAR, 32'h0000_00FA);
    rdc(tpu_pkg::OFS_STOP_STATE, 32'hFFFF_FFFF, 32'h0);
    // Minimum compare setting toggles the pin on every pclk tick.
    setup(0, 32'h0000_0181, 32'h1, 32'h0);
    setup(1, 32'h0000_0081, 32'h9, 32'h3);
    apb(1'b1, tpu_pkg::OFS_START_SET, 32'h0000_0003);
    rdc(tpu_pkg::OFS_RUN_STATE, 32'h3, 32'h3);
    @(negedge pclk);
    p = pwm_out[0];
    for (int i = 0; i < 6; i++) begin
      @(negedge pclk);
      chk({31'h0, pwm_out[0] ^ p}, 32'h1);
      p = pwm_out[0];
    end
    hi = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge pclk);
      if (pwm_out[1] === 1'b1) hi++;
    end
    chk(32'(hi), 32'd24);
    apb(1'b1, ca(1, tpu_pkg::CH_FULL), 32'd200);
    apb(1'b1, tpu_pkg::OFS_START_CLEAR, 32'h0000_0003);
    rdc(tpu_pkg::OFS_RUN_STATE, 32'h3, 32'h2);
    chk({31'h0, pwm_out[0]}, 32'h0);
    apb(1'b0, ca(0, tpu_pkg::CH_CNT), 32'h0);
    p = rd[0];
    rdc(ca(0, tpu_pkg::CH_CNT), 32'h1, {31'h0, p});
    repeat (220) @(posedge pclk);
    rdc(tpu_pkg::OFS_RUN_STATE, 32'h2, 32'h0);
    chk({31'h0, pwm_out[1]}, 32'h0);
    // Half above full: full matches only.
    setup(2, 32'h0000_0001, 32'h3, 32'h5);
    apb(1'b1, tpu_pkg::OFS_START_SET, 32'h0000_0004);
    repeat (30) @(posedge pclk);
    rdc(tpu_pkg::OFS_FLAGS, 32'h0004_0004, 32'h0000_0004);
    // Slow, crystal, divided pclk and an illegal two-source setting.
    setup(3, 32'h0000_0002, 32'hFFFF, 32'hFFFF);
    setup(4, 32'h0000_0004, 32'hFFFF, 32'hFFFF);
    setup(6, 32'h0000_0009, 32'hFFFF, 32'hFFFF);
    setup(7, 32'h0000_0003, 32'hFFFF, 32'hFFFF);
    apb(1'b1, tpu_pkg::OFS_START_SET, 32'h0000_00D8);
    repeat (100) @(posedge pclk);
    rdc(ca(3, tpu_pkg::CH_CNT), 32'h0, 32'h0);
    rng(rd, 8, 11);
    rdc(ca(4, tpu_pkg::CH_CNT), 32'h0, 32'h0);
    rng(rd, 22, 28);
    rdc(ca(6, tpu_pkg::CH_CNT), 32'h0, 32'h0);
    rng(rd, 23, 29);
    // With the enable low the counter freezes: four live edges give one divided tick.
    hi = int'(rd);
    @(posedge pclk);
    clk_en <= 1'b0;
    repeat (39) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, pready}, 32'h0);
    @(posedge pclk);
    clk_en <= 1'b1;
    rdc(ca(6, tpu_pkg::CH_CNT), 32'hFFFF, 32'(hi + 1));
    rdc(ca(7, tpu_pkg::CH_CNT), 32'hFFFF, 32'h0);
    // Channel five: compares set with the clock stopped, flags on equality.
    apb(1'b1, tpu_pkg::OFS_MASK, 32'h0020_0020);
    apb(1'b1, ca(5, tpu_pkg::CH_CTRL), 32'h0000_0100);
    apb(1'b1, ca(5, tpu_pkg::CH_FULL), 32'h7);
    apb(1'b1, ca(5, tpu_pkg::CH_HALF), 32'h3);
    apb(1'b1, tpu_pkg::OFS_FLAGS, 32'h0020_0020);
    rdc(tpu_pkg::OFS_FLAGS, 32'h0020_0020, 32'h0);
    apb(1'b1, ca(5, tpu_pkg::CH_CTRL), 32'h0000_0101);
    apb(1'b1, ca(5, tpu_pkg::CH_CNT), 32'h7);
    rdc(tpu_pkg::OFS_FLAGS, 32'h0020_0020, 32'h0000_0020);
    apb(1'b1, tpu_pkg::OFS_FLAGS, 32'h0000_0020);
    rdc(tpu_pkg::OFS_FLAGS, 32'h0020_0020, 32'h0000_0020);
    apb(1'b1, ca(5, tpu_pkg::CH_CTRL), 32'h0000_0100);
    apb(1'b1, ca(5, tpu_pkg::CH_FULL), 32'h8);
    apb(1'b1, tpu_pkg::OFS_FLAGS, 32'h0000_0020);
    rdc(tpu_pkg::OFS_FLAGS, 32'h0020_0020, 32'h0);
    apb(1'b1, ca(5, tpu_pkg::CH_CNT), 32'h3);
    rdc(tpu_pkg::OFS_FLAGS, 32'h0020_0020, 32'h0020_0000);
    apb(1'b1, ca(5, tpu_pkg::CH_FULL), 32'd200);
    apb(1'b1, ca(5, tpu_pkg::CH_HALF), 32'd100);
    apb(1'b1, ca(5, tpu_pkg::CH_CTRL), 32'h0000_0081);
    apb(1'b1, tpu_pkg::OFS_START_SET, 32'h0000_0020);
    repeat (5) @(posedge pclk);
    apb(1'b1, tpu_pkg::OFS_START_CLEAR, 32'h0000_0020);
    rdc(tpu_pkg::OFS_RUN_STATE, 32'h20, 32'h0);
    chk({31'h0, pwm_out[5]}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
